/* File: rss_pkg.sv */
// Package for the rotate, subtract and sleep execution unit
// Assumes a single 8-bit datapath on one clock
package rss_pkg;
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] WD_COUNT_CLEAR = 8'h00;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;
  localparam logic PWR_DOWN_RST = 1'b1;
  localparam logic EXPIRY_RST = 1'b1;
  localparam logic CARRY_RST = 1'b0;
  localparam logic NIB_RST = 1'b0;
  localparam logic ZERO_RST = 1'b0;
  typedef enum logic [2:0] {
    RSS_OP_NONE,
    RSS_OP_RLC,
    RSS_OP_RRC,
    RSS_OP_LIT_SUB,
    RSS_OP_REG_SUB,
    RSS_OP_SLEEP
  } rss_op_t;
endpackage

/* File: rss_exec.sv */
// Execution unit for rotate, subtract and sleep instructions
// Assumes the decoder presents one instruction per cycle with its operand
`timescale 1ns/100ps
`default_nettype none
module rss_exec
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Instruction
  input wire logic instr_valid,
  input wire rss_op_t instr_op,
  input wire logic instr_dest,
  input wire logic [DATA_W-1:0] instr_literal,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Register write-back
  output logic reg_we,
  output logic [DATA_W-1:0] reg_wdata,
  // Architectural state
  output logic [DATA_W-1:0] acc,
  output logic carry_bit,
  output logic nibble_borrow_bit,
  output logic zero_bit,
  output logic power_down_bit,
  output logic watchdog_expiry_bit,
  output logic watchdog_clear
);
  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  logic [DATA_W-1:0] acc_reg, acc_next, wd_reg, wd_next;
  logic c_reg, c_next, nb_reg, nb_next, z_reg, z_next;
  logic dn_reg, dn_next, ex_reg, ex_next;
  logic we_reg, we_next, wclr_reg, wclr_next;
  logic [DATA_W-1:0] minuend, res;
  logic [DATA_W:0] diff;
  logic [NIB_W:0] ndiff;
  logic do_write;

  always_comb begin
    acc_next = acc_reg;
    wd_next = wd_reg;
    c_next = c_reg;
    nb_next = nb_reg;
    z_next = z_reg;
    dn_next = dn_reg;
    ex_next = ex_reg;
    we_next = 1'b0;
    wclr_next = 1'b0;
    res = reg_rdata;
    do_write = 1'b0;
    minuend = (instr_op == RSS_OP_LIT_SUB) ? instr_literal : reg_rdata;
    diff = {1'b0, minuend} - {1'b0, acc_reg};
    ndiff = {1'b0, minuend[NIB_W-1:0]} - {1'b0, acc_reg[NIB_W-1:0]};
    if (instr_valid) begin
      case (instr_op)
        RSS_OP_RLC: begin
          res = {reg_rdata[DATA_W-2:0], c_reg};
          c_next = reg_rdata[DATA_W-1];
          do_write = 1'b1;
        end
        RSS_OP_RRC: begin
          res = {c_reg, reg_rdata[DATA_W-1:1]};
          c_next = reg_rdata[0];
          do_write = 1'b1;
        end
        RSS_OP_LIT_SUB: begin
          acc_next = diff[DATA_W-1:0];
          c_next = ~diff[DATA_W];
          nb_next = ~ndiff[NIB_W];
          z_next = (diff[DATA_W-1:0] == 8'h00);
        end
        RSS_OP_REG_SUB: begin
          res = diff[DATA_W-1:0];
          c_next = ~diff[DATA_W];
          nb_next = ~ndiff[NIB_W];
          z_next = (diff[DATA_W-1:0] == 8'h00);
          do_write = 1'b1;
        end
        RSS_OP_SLEEP: begin
          dn_next = 1'b0;
          ex_next = 1'b1;
          wclr_next = 1'b1;
        end
        default: begin
          do_write = 1'b0;
        end
      endcase
      if (do_write) begin
        if (instr_dest == DEST_ACC) begin
          acc_next = res;
        end else begin
          we_next = 1'b1;
          wd_next = res;
        end
      end
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= ACC_RST;
      wd_reg <= ACC_RST;
      c_reg <= CARRY_RST;
      nb_reg <= NIB_RST;
      z_reg <= ZERO_RST;
      dn_reg <= PWR_DOWN_RST;
      ex_reg <= EXPIRY_RST;
      we_reg <= 1'b0;
      wclr_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      wd_reg <= wd_next;
      c_reg <= c_next;
      nb_reg <= nb_next;
      z_reg <= z_next;
      dn_reg <= dn_next;
      ex_reg <= ex_next;
      we_reg <= we_next;
      wclr_reg <= wclr_next;
    end
  end

  assign acc = acc_reg;
  assign reg_we = we_reg;
  assign reg_wdata = wd_reg;
  assign carry_bit = c_reg;
  assign nibble_borrow_bit = nb_reg;
  assign zero_bit = z_reg;
  assign power_down_bit = dn_reg;
  assign watchdog_expiry_bit = ex_reg;
  assign watchdog_clear = wclr_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_rlc;
    @(posedge sys_clk) disable iff (!rst_n)
    instr_valid && instr_op == RSS_OP_RLC && instr_dest == DEST_REG |=>
      reg_we && reg_wdata == {$past(reg_rdata[6:0]), $past(c_reg)}
      && carry_bit == $past(reg_rdata[7]);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left wrong");

  property p_dest_acc;
    @(posedge sys_clk) disable iff (!rst_n)
    instr_valid && (instr_op == RSS_OP_RRC || instr_op == RSS_OP_REG_SUB)
      && instr_dest == DEST_ACC |=> !reg_we;
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("acc dest wrote register");

  property p_rrc;
    @(posedge sys_clk) disable iff (!rst_n)
    instr_valid && instr_op == RSS_OP_RRC && instr_dest == DEST_ACC |=>
      acc == {$past(c_reg), $past(reg_rdata[7:1])} && carry_bit == $past(reg_rdata[0]);
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right wrong");

  property p_sleep;
    @(posedge sys_clk) disable iff (!rst_n)
    instr_valid && instr_op == RSS_OP_SLEEP |=>
      !power_down_bit && watchdog_expiry_bit && watchdog_clear;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep effects wrong");

  property p_wclr_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
    watchdog_clear |-> $past(instr_valid) && $past(instr_op) == RSS_OP_SLEEP;
  endproperty
  a_wclr_pulse: assert property (p_wclr_pulse) else $error("stray watchdog clear");

  property p_lit_sub;
    @(posedge sys_clk) disable iff (!rst_n)
    instr_valid && instr_op == RSS_OP_LIT_SUB |=>
      acc == 8'($past(instr_literal) - $past(acc))
      && carry_bit == ($past(acc) <= $past(instr_literal))
      && nibble_borrow_bit == ($past(acc[3:0]) <= $past(instr_literal[3:0]));
  endproperty
  a_lit_sub: assert property (p_lit_sub) else $error("literal subtract wrong");

  property p_reg_sub;
    @(posedge sys_clk) disable iff (!rst_n)
    instr_valid && instr_op == RSS_OP_REG_SUB && instr_dest == DEST_REG |=>
      reg_wdata == 8'($past(reg_rdata) - $past(acc))
      && carry_bit == ($past(acc) <= $past(reg_rdata))
      && zero_bit == ($past(reg_rdata) == $past(acc));
  endproperty
  a_reg_sub: assert property (p_reg_sub) else $error("register subtract wrong");

  property p_rot_flags;
    @(posedge sys_clk) disable iff (!rst_n)
    instr_valid && (instr_op == RSS_OP_RLC || instr_op == RSS_OP_RRC) |=>
      $stable(zero_bit) && $stable(nibble_borrow_bit);
  endproperty
  a_rot_flags: assert property (p_rot_flags) else $error("rotate touched flags");

  property p_lit_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    instr_valid && instr_op == RSS_OP_LIT_SUB |=>
      zero_bit == ($past(instr_literal) == $past(acc));
  endproperty
  a_lit_zero: assert property (p_lit_zero) else $error("literal subtract zero wrong");

  property p_reg_sub_acc;
    @(posedge sys_clk) disable iff (!rst_n)
    instr_valid && instr_op == RSS_OP_REG_SUB && instr_dest == DEST_ACC |=>
      acc == 8'($past(reg_rdata) - $past(acc)) && !reg_we;
  endproperty
  a_reg_sub_acc: assert property (p_reg_sub_acc) else $error("subtract into acc wrong");

  property p_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    !instr_valid |=>
      $stable(acc) && $stable(carry_bit) && !reg_we && !watchdog_clear;
  endproperty
  a_idle: assert property (p_idle) else $error("idle cycle changed state");
endmodule // rss_exec
`default_nettype wire

/* File: rss_exec_bench.sv */
// Self-checking bench for the rotate, subtract and sleep unit
// Assumes rss_pkg and rss_exec are compiled first
`timescale 1ns/100ps
`default_nettype none
module rss_exec_bench;
  import rss_pkg::*;
  // ------
  // Signals
  // ------
  typedef struct packed {
    logic [7:0] acc, wd;
    logic c, nb, z, dn, ex, we, wc;
  } rss_note_t;
  logic sys_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, instr_dest = 1'b0;
  rss_op_t instr_op = RSS_OP_NONE;
  logic [7:0] instr_literal = 8'h00, reg_rdata = 8'h00, reg_wdata, acc;
  logic reg_we, carry_bit, nibble_borrow_bit, zero_bit, power_down_bit;
  logic watchdog_expiry_bit, watchdog_clear;
  int fail_count = 0, n_checks = 0;
  rss_note_t q[$], m, n;
  logic [31:0] s = 32'h0e6c07bf;
  rss_exec uut (.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_dest(instr_dest), .instr_literal(instr_literal),
    .reg_rdata(reg_rdata), .reg_we(reg_we), .reg_wdata(reg_wdata), .acc(acc),
    .carry_bit(carry_bit), .nibble_borrow_bit(nibble_borrow_bit),
    .zero_bit(zero_bit), .power_down_bit(power_down_bit),
    .watchdog_expiry_bit(watchdog_expiry_bit), .watchdog_clear(watchdog_clear));
  initial forever #20 sys_clk = ~sys_clk;
  // ------
  // Tasks
  // ------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic mreset();
    m = '{ACC_RST, 8'h00, CARRY_RST, NIB_RST, ZERO_RST, PWR_DOWN_RST, EXPIRY_RST, 1'b0, 1'b0};
  endtask
  // Drive one instruction and note its expected outcome
  task automatic step(input logic v, input logic [2:0] op, input logic d,
                      input logic [7:0] k, input logic [7:0] rd);
    logic [7:0] o, r;
    logic wr, dd;
    @(negedge sys_clk);
    instr_valid = v;
    instr_op = rss_op_t'(op);
    instr_dest = d;
    instr_literal = k;
    reg_rdata = rd;
    wr = 1'b0;
    dd = d;
    r = 8'h00;
    m.we = 1'b0;
    m.wc = 1'b0;
    if (v) begin
      case (instr_op)
        RSS_OP_RLC, RSS_OP_RRC: begin
          r = (instr_op == RSS_OP_RLC) ? {rd[6:0], m.c} : {m.c, rd[7:1]};
          m.c = (instr_op == RSS_OP_RLC) ? rd[7] : rd[0];
          wr = 1'b1;
        end
        RSS_OP_LIT_SUB, RSS_OP_REG_SUB: begin
          o = (instr_op == RSS_OP_LIT_SUB) ? k : rd;
          r = o - m.acc;
          m.c = (m.acc <= o);
          m.nb = (m.acc[3:0] <= o[3:0]);
          m.z = (r == 8'h00);
          dd = (instr_op == RSS_OP_REG_SUB) && d;
          wr = 1'b1;
        end
        RSS_OP_SLEEP: begin
          m.dn = 1'b0;
          m.ex = 1'b1;
          m.wc = 1'b1;
        end
        default: ;
      endcase
    end
    if (wr && dd == DEST_REG) begin
      m.we = 1'b1;
      m.wd = r;
    end else if (wr) begin
      m.acc = r;
    end
    q.push_back(m);
  endtask
  // ------
  // Processes
  // ------
  initial forever begin
    @(posedge sys_clk);
    #1;
    if (q.size() > 0) begin
      n = q.pop_front();
      chk(acc, n.acc);
      chk(carry_bit, n.c);
      chk(nibble_borrow_bit, n.nb);
      chk(zero_bit, n.z);
      chk(reg_we, n.we);
      if (n.we) chk(reg_wdata, n.wd);
      chk(power_down_bit, n.dn);
      chk(watchdog_expiry_bit, n.ex);
      chk(watchdog_clear, n.wc);
    end
  end
  initial begin
    #(40 * 1000);
    fail_count++;
    print_verdict();
  end
  initial begin
    mreset();
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    step(1'b1, 3'h3, 1'b0, 8'h03, 8'h00);
    step(1'b1, 3'h4, 1'b1, 8'h00, 8'h05);
    step(1'b1, 3'h4, 1'b0, 8'h00, 8'h03);
    step(1'b1, 3'h1, 1'b0, 8'h00, 8'he6);
    step(1'b1, 3'h2, 1'b1, 8'h00, 8'h01);
    step(1'b1, 3'h5, 1'b0, 8'h00, 8'h00);
    step(1'b1, 3'h3, 1'b0, 8'h10, 8'h00);
    repeat (400) begin
      s = lfsr(s);
      step(s[8] | s[9], s[2:0], s[3], s[15:8], s[23:16]);
    end
    step(1'b0, 3'd0, 1'b0, 8'h00, 8'h00);
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    mreset();
    rst_n = 1'b1;
    step(1'b0, 3'd0, 1'b0, 8'h00, 8'h00);
    repeat (2) @(negedge sys_clk);
    print_verdict();
  end
endmodule // rss_exec_bench
`default_nettype wire
